/* common/mmd_defs.svh */
/*
 * Address constants of the memory map decoder.
 * Assumes a 16-bit processor address bus.
 */
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define MMD_ADDR_W 16
`define MMD_DATA_W 8

// ----------------------------------------
// region bounds
// ----------------------------------------
`define MMD_IO_LO       16'h0000
`define MMD_IO_HI       16'h003F
`define MMD_RSV_LO      16'h0040
`define MMD_RSV_HI      16'h007F
`define MMD_RAM_LO      16'h0080
`define MMD_RAM_HI      16'h00FF
`define MMD_AUX_LO      16'h2800
`define MMD_AUX_HI      16'h2DFF
`define MMD_FL_BIG_LO   16'hEE00
`define MMD_FL_SMALL_LO 16'hF800
`define MMD_FL_HI       16'hFDFF
`define MMD_FTEST_LO    16'hFE0D
`define MMD_FTEST_HI    16'hFE0F
`define MMD_MON_LO      16'hFE10
`define MMD_MON_HI      16'hFFAF
`define MMD_FLX1_LO     16'hFFB0
`define MMD_FLX1_HI     16'hFFBD
`define MMD_FLX2_LO     16'hFFC2
`define MMD_FLX2_HI     16'hFFCF
`define MMD_VEC_LO      16'hFFD0
`define MMD_VEC_HI      16'hFFFF

// ----------------------------------------
// single locations
// ----------------------------------------
`define MMD_BRK_STAT    16'hFE00
`define MMD_RST_CAUSE   16'hFE01
`define MMD_BRK_AUX     16'hFE02
`define MMD_BRK_FLAG    16'hFE03
`define MMD_IRQ_ST1     16'hFE04
`define MMD_IRQ_ST2     16'hFE05
`define MMD_IRQ_ST3     16'hFE06
`define MMD_FTEST_CTRL  16'hFE07
`define MMD_FLASH_CTRL  16'hFE08
`define MMD_BRK_ADDR_H  16'hFE09
`define MMD_BRK_ADDR_L  16'hFE0A
`define MMD_BRK_SC      16'hFE0B
`define MMD_LVI_STAT    16'hFE0C
`define MMD_PROTECT     16'hFFBE
`define MMD_RSV_FL1     16'hFFBF
`define MMD_TRIM        16'hFFC0
`define MMD_RSV_FL2     16'hFFC1

`define MMD_RDATA_IDLE  8'h00

`endif

/* common/mmd_pkg.sv */
/*
 * Types shared by the memory map decoder files.
 * Assumes mmd_defs.svh is on the include path.
 */
`include "mmd_defs.svh"

package mmd_pkg;

  typedef enum logic [3:0] {
    MMD_RG_NONE, MMD_RG_IO, MMD_RG_RSV_LOW, MMD_RG_RAM, MMD_RG_UNIMPL,
    MMD_RG_AUX_ROM, MMD_RG_FLASH, MMD_RG_HI_REG, MMD_RG_RSV_TEST,
    MMD_RG_MON_ROM, MMD_RG_PROTECT, MMD_RG_TRIM, MMD_RG_RSV_FLASH,
    MMD_RG_VECTORS
  } mmd_region_e;

  typedef struct packed {
    logic ioPage;
    logic ram;
    logic auxRom;
    logic flash;
    logic monRom;
    logic vectors;
    logic protect;
    logic trim;
    logic breakStatusSelect;
    logic resetCauseSelect;
    logic breakAuxSelect;
    logic breakFlagCtrlSelect;
    logic irqSourceStatusOne;
    logic irqSourceStatusTwo;
    logic irqSourceStatusThree;
    logic flashCtrlSelect;
    logic breakAddrHighSelect;
    logic breakAddrLowSelect;
    logic breakStatCtrlSelect;
    logic lviStatusSelect;
  } mmd_sel_s;

  typedef struct packed {
    logic [`MMD_DATA_W-1:0] ioPage;
    logic [`MMD_DATA_W-1:0] ram;
    logic [`MMD_DATA_W-1:0] auxRom;
    logic [`MMD_DATA_W-1:0] flash;
    logic [`MMD_DATA_W-1:0] hiReg;
    logic [`MMD_DATA_W-1:0] monRom;
  } mmd_rdata_s;

  function automatic logic mmd_in_range(
    input logic [`MMD_ADDR_W-1:0] a,
    input logic [`MMD_ADDR_W-1:0] lo,
    input logic [`MMD_ADDR_W-1:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction : mmd_in_range

endpackage : mmd_pkg

/* src/mmd_region_decode.sv */
/*
 * Combinational address to region and select decode.
 * Assumes the caller registers the results.
 */
`include "mmd_defs.svh"
module mmd_region_decode #(
  parameter bit LARGE_FLASH = 1'b1
) (
  // address
  input  wire logic [`MMD_ADDR_W-1:0] addr,
  // decode result
  output mmd_pkg::mmd_region_e        region,
  output mmd_pkg::mmd_sel_s           sel
);
  import mmd_pkg::*;

  logic [`MMD_ADDR_W-1:0] flashLo;

  assign flashLo = LARGE_FLASH ? `MMD_FL_BIG_LO : `MMD_FL_SMALL_LO;

  always_comb begin
    sel    = '0;
    region = MMD_RG_UNIMPL;
    if (mmd_in_range(addr, `MMD_IO_LO, `MMD_IO_HI)) begin
      region     = MMD_RG_IO;
      sel.ioPage = 1'b1;
    end else if (mmd_in_range(addr, `MMD_RSV_LO, `MMD_RSV_HI)) begin
      region = MMD_RG_RSV_LOW;
    end else if (mmd_in_range(addr, `MMD_RAM_LO, `MMD_RAM_HI)) begin
      region  = MMD_RG_RAM;
      sel.ram = 1'b1;
    end else if (mmd_in_range(addr, `MMD_AUX_LO, `MMD_AUX_HI)) begin
      region     = MMD_RG_AUX_ROM;
      sel.auxRom = 1'b1;
    end else if (mmd_in_range(addr, flashLo, `MMD_FL_HI)) begin
      region    = MMD_RG_FLASH;
      sel.flash = 1'b1;
    end else if (addr == `MMD_BRK_STAT) begin
      region                = MMD_RG_HI_REG;
      sel.breakStatusSelect = 1'b1;
    end else if (addr == `MMD_RST_CAUSE) begin
      region               = MMD_RG_HI_REG;
      sel.resetCauseSelect = 1'b1;
    end else if (addr == `MMD_BRK_AUX) begin
      region             = MMD_RG_HI_REG;
      sel.breakAuxSelect = 1'b1;
    end else if (addr == `MMD_BRK_FLAG) begin
      region                  = MMD_RG_HI_REG;
      sel.breakFlagCtrlSelect = 1'b1;
    end else if (addr == `MMD_IRQ_ST1) begin
      region                 = MMD_RG_HI_REG;
      sel.irqSourceStatusOne = 1'b1;
    end else if (addr == `MMD_IRQ_ST2) begin
      region                 = MMD_RG_HI_REG;
      sel.irqSourceStatusTwo = 1'b1;
    end else if (addr == `MMD_IRQ_ST3) begin
      region                   = MMD_RG_HI_REG;
      sel.irqSourceStatusThree = 1'b1;
    end else if (addr == `MMD_FTEST_CTRL ||
                 mmd_in_range(addr, `MMD_FTEST_LO, `MMD_FTEST_HI)) begin
      region = MMD_RG_RSV_TEST;
    end else if (addr == `MMD_FLASH_CTRL) begin
      region              = MMD_RG_HI_REG;
      sel.flashCtrlSelect = 1'b1;
    end else if (addr == `MMD_BRK_ADDR_H) begin
      region                  = MMD_RG_HI_REG;
      sel.breakAddrHighSelect = 1'b1;
    end else if (addr == `MMD_BRK_ADDR_L) begin
      region                 = MMD_RG_HI_REG;
      sel.breakAddrLowSelect = 1'b1;
    end else if (addr == `MMD_BRK_SC) begin
      region                  = MMD_RG_HI_REG;
      sel.breakStatCtrlSelect = 1'b1;
    end else if (addr == `MMD_LVI_STAT) begin
      region              = MMD_RG_HI_REG;
      sel.lviStatusSelect = 1'b1;
    end else if (mmd_in_range(addr, `MMD_MON_LO, `MMD_MON_HI)) begin
      region     = MMD_RG_MON_ROM;
      sel.monRom = 1'b1;
    end else if (addr == `MMD_PROTECT) begin
      region      = MMD_RG_PROTECT;
      sel.protect = 1'b1;
    end else if (addr == `MMD_RSV_FL1 || addr == `MMD_RSV_FL2) begin
      region = MMD_RG_RSV_FLASH;
    end else if (addr == `MMD_TRIM) begin
      region   = MMD_RG_TRIM;
      sel.trim = 1'b1;
    end else if (mmd_in_range(addr, `MMD_FLX1_LO, `MMD_FLX1_HI) ||
                 mmd_in_range(addr, `MMD_FLX2_LO, `MMD_FLX2_HI)) begin
      region    = MMD_RG_FLASH;
      sel.flash = 1'b1;
    end else if (mmd_in_range(addr, `MMD_VEC_LO, `MMD_VEC_HI)) begin
      region      = MMD_RG_VECTORS;
      sel.vectors = 1'b1;
    end
  end

endmodule : mmd_region_decode

/* src/mmd_memory_map_decoder.sv */
/*
 * Memory map decoder: registers the target select for each processor
 * access, returns read data one cycle after the select and raises an
 * illegal-address reset request for bad instruction fetches.
 * Assumes targets answer combinationally while their select is high.
 */
`include "mmd_defs.svh"
// How it works
// - a 16-bit address spans 64 Kbytes; each address has one region class.
// - $0000-$003F selects the peripheral register page.
// - $0080-$00FF selects the 128-byte RAM as plain storage.
// - large-flash variant selects user flash at $EE00-$FDFF.
// - small-flash variant selects the main flash window only at $F800-$FDFF; below is unimplemented.
// - $2800-$2DFF selects the 1536-byte auxiliary ROM.
// - $FE10-$FFAF selects the 416-byte monitor ROM.
// - $FFD0-$FFFF selects the 48-byte user vector area in flash.
// - $FE00-$FE03 select break status, reset cause, break aux, break flag.
// - $FE04-$FE06 select interrupt source status one, two, three.
// - $FE07 and $FE0D-$FE0F are reserved flash test, no select.
// - $FE08 selects the flash control register.
// - $FE09-$FE0B select break address high, low, status and control.
// - $FFBE selects flash protect; $FFBF and $FFC1 are reserved flash.
// - $FFC0 selects the stored oscillator trim value.
// - fetch from $0040-$007F or unimplemented space requests illegal-address reset.
module mmd_memory_map_decoder #(
  parameter bit LARGE_FLASH = 1'b1
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // processor access
  input  wire logic                   cpuReq,
  input  wire logic                   cpuFetch,
  input  wire logic                   cpuWrite,
  input  wire logic [`MMD_ADDR_W-1:0] cpuAddr,
  // target side
  input  mmd_pkg::mmd_rdata_s         tgtRdata,
  output mmd_pkg::mmd_sel_s           sel,
  output mmd_pkg::mmd_region_e        region,
  output logic                        selWrite,
  // read return
  output logic                        rdValid,
  output logic [`MMD_DATA_W-1:0]      cpuRdata,
  // reset request
  output logic                        illegalAddrRst
);
  import mmd_pkg::*;

  // ----------------------------------------
  // decode stage
  // ----------------------------------------
  mmd_region_e            decRegion;
  mmd_sel_s               decSel;
  mmd_region_e            next_region;
  mmd_sel_s               next_sel;
  logic                   next_selWrite;
  logic                   next_illegalAddrRst;
  logic                   badFetchRegion;

  mmd_region_decode #(
    .LARGE_FLASH (LARGE_FLASH)
  ) u_decode (
    .addr   (cpuAddr),
    .region (decRegion),
    .sel    (decSel)
  );

  assign badFetchRegion = (decRegion == MMD_RG_RSV_LOW) ||
                          (decRegion == MMD_RG_UNIMPL);

  always_comb begin
    next_region         = MMD_RG_NONE;
    next_sel            = '0;
    next_selWrite       = 1'b0;
    next_illegalAddrRst = 1'b0;
    if (cpuReq) begin
      next_region   = decRegion;
      next_sel      = decSel;
      next_selWrite = cpuWrite;
      next_illegalAddrRst = cpuFetch && badFetchRegion;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      region         <= MMD_RG_NONE;
      sel            <= '0;
      selWrite       <= 1'b0;
      illegalAddrRst <= 1'b0;
    end else begin
      region         <= next_region;
      sel            <= next_sel;
      selWrite       <= next_selWrite;
      illegalAddrRst <= next_illegalAddrRst;
    end
  end

  // ----------------------------------------
  // read return stage
  // ----------------------------------------
  logic                   next_rdValid;
  logic [`MMD_DATA_W-1:0] next_cpuRdata;

  // flash, vectors, protect and trim share the flash array port;
  // all high-page register selects share one return byte
  always_comb begin
    next_rdValid  = (region != MMD_RG_NONE) && !selWrite;
    next_cpuRdata = `MMD_RDATA_IDLE;
    if (next_rdValid) begin
      if (sel.ioPage) begin
        next_cpuRdata = tgtRdata.ioPage;
      end else if (sel.ram) begin
        next_cpuRdata = tgtRdata.ram;
      end else if (sel.auxRom) begin
        next_cpuRdata = tgtRdata.auxRom;
      end else if (sel.flash || sel.vectors || sel.protect || sel.trim) begin
        next_cpuRdata = tgtRdata.flash;
      end else if (sel.monRom) begin
        next_cpuRdata = tgtRdata.monRom;
      end else if (region == MMD_RG_HI_REG) begin
        next_cpuRdata = tgtRdata.hiReg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdValid  <= 1'b0;
      cpuRdata <= `MMD_RDATA_IDLE;
    end else begin
      rdValid  <= next_rdValid;
      cpuRdata <= next_cpuRdata;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic acc;
  assign acc = cpuReq;

  a_class_per_access:
    assert property (acc |=> region != MMD_RG_NONE)
      else $error("access left without a region class");

  a_idle_no_class:
    assert property (!acc |=> region == MMD_RG_NONE && sel == '0)
      else $error("idle cycle shows a region or select");

  a_io_page_sel:
    assert property (acc && mmd_in_range(cpuAddr, `MMD_IO_LO, `MMD_IO_HI)
                     |=> sel.ioPage && region == MMD_RG_IO)
      else $error("io page not selected");

  a_ram_sel_write:
    assert property (acc && cpuWrite &&
                     mmd_in_range(cpuAddr, `MMD_RAM_LO, `MMD_RAM_HI)
                     |=> sel.ram && selWrite ##1 !rdValid)
      else $error("ram write not selected or answered as read");

  a_big_flash_sel:
    assert property (LARGE_FLASH && acc &&
                     mmd_in_range(cpuAddr, `MMD_FL_BIG_LO, `MMD_FL_HI)
                     |=> sel.flash)
      else $error("large flash window not selected");

  a_small_flash_gap:
    assert property (!LARGE_FLASH && acc &&
                     mmd_in_range(cpuAddr, `MMD_FL_BIG_LO, 16'hF7FF)
                     |=> region == MMD_RG_UNIMPL && !sel.flash)
      else $error("small variant selects flash below its base");

  a_small_flash_sel:
    assert property (acc &&
                     mmd_in_range(cpuAddr, `MMD_FL_SMALL_LO, `MMD_FL_HI)
                     |=> sel.flash)
      else $error("flash top window not selected");

  a_aux_rom_sel:
    assert property (acc && mmd_in_range(cpuAddr, `MMD_AUX_LO, `MMD_AUX_HI)
                     |=> sel.auxRom)
      else $error("auxiliary rom not selected");

  a_aux_rom_edge:
    assert property (acc && cpuAddr == 16'h2E00 |=> region == MMD_RG_UNIMPL)
      else $error("auxiliary rom decoded past its end");

  a_mon_rom_sel:
    assert property (acc && mmd_in_range(cpuAddr, `MMD_MON_LO, `MMD_MON_HI)
                     |=> sel.monRom)
      else $error("monitor rom not selected");

  a_vector_sel:
    assert property (acc && mmd_in_range(cpuAddr, `MMD_VEC_LO, `MMD_VEC_HI)
                     |=> sel.vectors && !sel.flash)
      else $error("vector area not selected");

  a_break_reg_sel:
    assert property (acc && cpuAddr == `MMD_BRK_FLAG
                     |=> sel.breakFlagCtrlSelect && !sel.breakAuxSelect)
      else $error("break flag control not selected");

  a_reset_cause_sel:
    assert property (acc && cpuAddr == `MMD_RST_CAUSE |=> sel.resetCauseSelect)
      else $error("reset cause not selected");

  a_irq_stat_sel:
    assert property (acc && cpuAddr == `MMD_IRQ_ST3
                     |=> sel.irqSourceStatusThree && !sel.irqSourceStatusTwo)
      else $error("interrupt status three not selected");

  a_ftest_no_sel:
    assert property (acc && (cpuAddr == `MMD_FTEST_CTRL ||
                     mmd_in_range(cpuAddr, `MMD_FTEST_LO, `MMD_FTEST_HI))
                     |=> sel == '0 && region == MMD_RG_RSV_TEST)
      else $error("flash test location produced a select");

  a_flash_ctrl_sel:
    assert property (acc && cpuAddr == `MMD_FLASH_CTRL |=> sel.flashCtrlSelect)
      else $error("flash control not selected");

  a_break_addr_sel:
    assert property (acc && cpuAddr == `MMD_BRK_ADDR_L
                     |=> sel.breakAddrLowSelect && !sel.breakAddrHighSelect)
      else $error("break address low not selected");

  a_protect_sel:
    assert property (acc && cpuAddr == `MMD_PROTECT |=> sel.protect)
      else $error("flash protect not selected");

  a_rsv_flash_none:
    assert property (acc && (cpuAddr == `MMD_RSV_FL1 || cpuAddr == `MMD_RSV_FL2)
                     |=> sel == '0)
      else $error("reserved flash produced a select");

  a_trim_sel:
    assert property (acc && cpuAddr == `MMD_TRIM |=> sel.trim)
      else $error("trim location not selected");

  a_low_rsv_fetch:
    assert property (acc && cpuFetch &&
                     mmd_in_range(cpuAddr, `MMD_RSV_LO, `MMD_RSV_HI)
                     |=> illegalAddrRst)
      else $error("reserved fetch raised no reset request");

  a_ram_fetch_ok:
    assert property (acc && cpuFetch &&
                     mmd_in_range(cpuAddr, `MMD_RAM_LO, `MMD_RAM_HI)
                     |=> !illegalAddrRst)
      else $error("legal fetch raised a reset request");

  a_data_no_reset:
    assert property (acc && !cpuFetch |=> !illegalAddrRst)
      else $error("data access raised a reset request");

  a_one_select:
    assert property ($onehot0(sel))
      else $error("more than one select active");

  a_unimpl_none:
    assert property (region == MMD_RG_UNIMPL || region == MMD_RG_RSV_LOW
                     |-> sel == '0)
      else $error("unimplemented region carries a select");

  a_unsel_read_zero:
    assert property (acc && !cpuWrite && !cpuFetch &&
                     mmd_in_range(cpuAddr, `MMD_RSV_LO, `MMD_RSV_HI)
                     |=> ##1 rdValid && cpuRdata == `MMD_RDATA_IDLE)
      else $error("unselected read returned nonzero data");

  a_ram_read_data:
    assert property (sel.ram && !selWrite
                     |=> rdValid && cpuRdata == $past(tgtRdata.ram))
      else $error("ram read data not returned");

  a_reset_pulse_cause:
    assert property (illegalAddrRst |-> $past(acc && cpuFetch && badFetchRegion))
      else $error("reset request without a bad fetch");

  a_reset_single:
    assert property (acc && cpuFetch && badFetchRegion ##1 !acc
                     |=> !illegalAddrRst)
      else $error("reset request held beyond one cycle");

  c_ram_read:
    cover property (acc && !cpuWrite && cpuAddr == `MMD_RAM_LO ##2 rdValid);

  c_bad_fetch:
    cover property (acc && cpuFetch && cpuAddr == 16'h0100 ##1 illegalAddrRst);

  c_vector_fetch:
    cover property (acc && cpuFetch && cpuAddr == `MMD_VEC_HI ##1 sel.vectors);

  c_break_write:
    cover property (acc && cpuWrite && cpuAddr == `MMD_BRK_SC ##1 selWrite);

endmodule : mmd_memory_map_decoder

/* testbench/mmd_target_model.sv */
/*
 * Target side model: memories and register pages behind the decoder.
 * Assumes selects are registered by the decoder and that data is
 * sampled while the select is high, so the model answers combinationally.
 */
module mmd_target_model (
  // clock
  input  wire logic          core_clk,
  // selects in, read bytes out
  input  mmd_pkg::mmd_sel_s  sel,
  output mmd_pkg::mmd_rdata_s tgtRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  import mmd_pkg::*;

  // unselected targets show a moving pattern, so a stale byte never passes
  logic [7:0] noise = 8'h5A;

  always_ff @(posedge core_clk) begin
    noise <= noise + 8'h01;
  end

  always_comb begin
    tgtRdata.ioPage = sel.ioPage ? 8'h11 : noise;
    tgtRdata.ram    = sel.ram ? 8'h22 : ~noise;
    tgtRdata.auxRom = sel.auxRom ? 8'h33 : noise;
    tgtRdata.flash  = (sel.flash | sel.vectors | sel.protect | sel.trim) ? 8'h44 : ~noise;
    tgtRdata.hiReg  = (|sel[11:0]) ? 8'h55 : noise;
    tgtRdata.monRom = sel.monRom ? 8'h66 : ~noise;
  end
endmodule : mmd_target_model

/* testbench/tb_memory_map_decoder.sv */
/*
 * Self-checking bench for the memory map decoder, both flash variants.
 * Assumes the hand-over latencies: select one cycle, read data two.
 */
module tb_memory_map_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  import mmd_pkg::*;

  logic core_clk = 1'h0;
  logic rst_n    = 1'h0;
  logic cpuReq   = 1'h0;
  logic cpuFetch = 1'h0;
  logic cpuWrite = 1'h0;
  logic [15:0] cpuAddr = 16'h0000;
  mmd_rdata_s tgtRdata;
  mmd_sel_s sel, selS;
  mmd_region_e region, regionS;
  logic selWrite, rdValid, illegalAddrRst, illegalS;
  logic [7:0] cpuRdata;
  int n_errors = 0;
  int cmp_count = 0;
  logic [15:0] mapAddr [28] = '{16'h0000, 16'h003F, 16'h0040, 16'h007F, 16'h0080, 16'h00FF,
    16'h0100, 16'h27FF, 16'h2800, 16'h2DFF, 16'h2E00, 16'hEDFF, 16'hEE00, 16'hF7FF,
    16'hF800, 16'hFDFF, 16'hFE10, 16'hFFAF, 16'hFFB0, 16'hFFBD, 16'hFFBE, 16'hFFBF,
    16'hFFC0, 16'hFFC1, 16'hFFC2, 16'hFFCF, 16'hFFD0, 16'hFFFF};
  logic [15:0] fetchAddr [12] = '{16'h0040, 16'h007F, 16'h0100, 16'h27FF, 16'h2E00,
    16'hEDFF, 16'hF7FF, 16'hFE07, 16'hFE0D, 16'hFFBF, 16'h0080, 16'hEE00};

  always #2.5 core_clk = ~core_clk;

  mmd_memory_map_decoder #(.LARGE_FLASH(1'h1)) mmd_memory_map_decoder_i (
    .core_clk(core_clk), .rst_n(rst_n), .cpuReq(cpuReq), .cpuFetch(cpuFetch),
    .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .tgtRdata(tgtRdata), .sel(sel),
    .region(region), .selWrite(selWrite), .rdValid(rdValid), .cpuRdata(cpuRdata),
    .illegalAddrRst(illegalAddrRst));
  // small variant shares the processor side
  mmd_memory_map_decoder #(.LARGE_FLASH(1'h0)) mmd_memory_map_decoder_small_i (
    .core_clk(core_clk), .rst_n(rst_n), .cpuReq(cpuReq), .cpuFetch(cpuFetch),
    .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .tgtRdata(tgtRdata), .sel(selS),
    .region(regionS), .selWrite(), .rdValid(), .cpuRdata(), .illegalAddrRst(illegalS));
  mmd_target_model mmd_target_model_i (.core_clk(core_clk), .sel(sel), .tgtRdata(tgtRdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h at %0t", n, e, g, $time);
    end
  endtask : chk

  function automatic void dec(input logic [15:0] a, input bit big, output mmd_region_e r,
                              output mmd_sel_s s, output logic [7:0] d);
    logic [19:0] b;
    b = '0;
    d = 8'h00;
    r = MMD_RG_UNIMPL;
    if (a <= 16'h003F) begin r = MMD_RG_IO; b[19] = 1'h1; d = 8'h11; end
    else if (a <= 16'h007F) r = MMD_RG_RSV_LOW;
    else if (a <= 16'h00FF) begin r = MMD_RG_RAM; b[18] = 1'h1; d = 8'h22; end
    else if (a >= 16'h2800 && a <= 16'h2DFF) begin r = MMD_RG_AUX_ROM; b[17] = 1'h1; d = 8'h33; end
    else if (a >= (big ? 16'hEE00 : 16'hF800) && a <= 16'hFDFF) begin
      r = MMD_RG_FLASH; b[16] = 1'h1; d = 8'h44;
    end
    else if (a >= 16'hFE00 && a <= 16'hFE0C && a != 16'hFE07) begin
      r = MMD_RG_HI_REG; d = 8'h55;
      b[(a[3:0] < 4'h7) ? 11 - int'(a[3:0]) : 12 - int'(a[3:0])] = 1'h1;
    end
    else if (a >= 16'hFE07 && a <= 16'hFE0F) r = MMD_RG_RSV_TEST;
    else if (a >= 16'hFE10 && a <= 16'hFFAF) begin r = MMD_RG_MON_ROM; b[15] = 1'h1; d = 8'h66; end
    else if (a == 16'hFFBE) begin r = MMD_RG_PROTECT; b[13] = 1'h1; d = 8'h44; end
    else if (a == 16'hFFBF || a == 16'hFFC1) r = MMD_RG_RSV_FLASH;
    else if (a == 16'hFFC0) begin r = MMD_RG_TRIM; b[12] = 1'h1; d = 8'h44; end
    else if (a >= 16'hFFD0) begin r = MMD_RG_VECTORS; b[14] = 1'h1; d = 8'h44; end
    else if (a >= 16'hFFB0) begin r = MMD_RG_FLASH; b[16] = 1'h1; d = 8'h44; end
    s = mmd_sel_s'(b);
  endfunction : dec

  // one isolated access, judged in both answer cycles
  task automatic acc(input logic [15:0] a, input logic f, input logic w);
    mmd_region_e r, rs;
    mmd_sel_s s, ss;
    logic [7:0] d, ds;
    dec(a, 1'h1, r, s, d);
    dec(a, 1'h0, rs, ss, ds);
    cpuReq = 1'h1; cpuAddr = a; cpuFetch = f; cpuWrite = w;
    @(posedge core_clk); #1;
    cpuReq = 1'h0;
    chk("region", r, region);
    chk("sel", s, sel);
    chk("selWrite", w, selWrite);
    chk("illegal", f && (r == MMD_RG_RSV_LOW || r == MMD_RG_UNIMPL), illegalAddrRst);
    chk("regionSmall", rs, regionS);
    chk("selSmall", ss, selS);
    chk("illegalSmall", f && (rs == MMD_RG_RSV_LOW || rs == MMD_RG_UNIMPL), illegalS);
    @(posedge core_clk); #1;
    chk("rdValid", !w, rdValid);
    chk("rdata", w ? 8'h00 : d, cpuRdata);
    chk("illegalEnd", 1'h0, illegalAddrRst);
  endtask : acc

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    cpuReq = 1'h1; cpuFetch = 1'h1; cpuAddr = 16'h0040;
    repeat (9) @(posedge core_clk);
    #1;
    chk("rstSel", '0, sel);
    chk("rstIllegal", 1'h0, illegalAddrRst);
    cpuReq = 1'h0; cpuFetch = 1'h0; rst_n = 1'h1;
    @(posedge core_clk); #1;
    chk("rstRegion", MMD_RG_NONE, region);
  endtask : t_reset

  task automatic t_map;
    foreach (mapAddr[i]) acc(mapAddr[i], 1'h0, 1'h0);
    for (int k = 0; k < 16; k++) acc(16'hFE00 + 16'(k), 1'h0, 1'h0);
  endtask : t_map

  task automatic t_fetch;
    foreach (fetchAddr[i]) acc(fetchAddr[i], 1'h1, 1'h0);
    acc(16'hFFFF, 1'h1, 1'h0);
    acc(16'h0040, 1'h0, 1'h0);
  endtask : t_fetch

  task automatic t_write;
    acc(16'h0080, 1'h0, 1'h1);
    acc(16'hFE08, 1'h0, 1'h1);
    acc(16'hFE0B, 1'h0, 1'h1);
    acc(16'h0040, 1'h0, 1'h1);
  endtask : t_write

  // two bad fetches back to back keep the request up two cycles
  task automatic t_b2b;
    cpuReq = 1'h1; cpuFetch = 1'h1; cpuWrite = 1'h0; cpuAddr = 16'h0040;
    @(posedge core_clk); #1;
    cpuAddr = 16'h2E00;
    chk("b2bFirst", 1'h1, illegalAddrRst);
    @(posedge core_clk); #1;
    cpuReq = 1'h0; cpuFetch = 1'h0;
    chk("b2bSecond", 1'h1, illegalAddrRst);
    chk("b2bRdata", 8'h00, cpuRdata);
    @(posedge core_clk); #1;
    chk("b2bDrop", 1'h0, illegalAddrRst);
    chk("b2bValid", 1'h1, rdValid);
    @(posedge core_clk); #1;
    chk("b2bIdle", 1'h0, rdValid);
  endtask : t_b2b

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hung");
    complete_run();
  end

  initial begin
    @(posedge core_clk); #1;
    t_reset();
    t_map();
    t_fetch();
    t_write();
    t_b2b();
    complete_run();
  end
endmodule : tb_memory_map_decoder
